// >>> design/ispr_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the pixel readout
// Assumes: 32-bit classic Wishbone register words, one per aligned word
// Notes: Definitions only
`ifndef ISPR_PARAMS_SVH
`define ISPR_PARAMS_SVH

// Array geometry
`define ISPR_ARRAY_COLS 16'h0AC0
`define ISPR_ARRAY_ROWS 16'h07D4
`define ISPR_COL_DARK0_END 16'h0009
`define ISPR_COL_BND0_END 16'h000F
`define ISPR_COL_ACT_END 16'h0A2F
`define ISPR_COL_BND1_END 16'h0A39
`define ISPR_ROW_DARK0_END 16'h0031
`define ISPR_ROW_BND0_END 16'h0035
`define ISPR_ROW_ACT_END 16'h07CD
`define ISPR_ROW_BND1_END 16'h07D1
`define ISPR_FIRST_COL 16'h0010
`define ISPR_FIRST_ROW 16'h0036

// Line timing, in pixel clocks and rows
`define ISPR_LV_OFFSET 16'h0261
`define ISPR_DARK_ROWS 16'h0008

// Register offsets
`define ISPR_REG_CTRL 8'h00
`define ISPR_REG_EXPO 8'h04
`define ISPR_REG_STATUS 8'h08
`define ISPR_REG_POS 8'h0C

// Control fields
`define ISPR_CTRL_SHOW_DARK 0
`define ISPR_CTRL_FIXED_BL 1
`define ISPR_CTRL_MODE_LO 2
`define ISPR_CTRL_BIN_LO 4
`define ISPR_CTRL_SKIP_LO 6
`define ISPR_CTRL_RST 8'h00
`define ISPR_EXPO_RST 16'h0010

`endif

// >>> design/ispr_pkg.sv
// Purpose: Types of the pixel readout
// Assumes: Nothing beyond the params header
// Notes: Nothing is imported by users
package ispr_pkg;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_EXPOSE = 2'b01,
    ST_READOUT = 2'b10
  } ispr_state_e;

  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_SNAP = 2'b01,
    MODE_BULB = 2'b10
  } ispr_mode_e;

  typedef enum logic [1:0] {
    CH_GREEN_RED_PIXEL = 2'b00,
    CH_RED = 2'b01,
    CH_BLUE = 2'b10,
    CH_GREEN_BLUE_PIXEL = 2'b11
  } ispr_chan_e;

  typedef enum logic [1:0] {
    ZONE_DARK = 2'b00,
    ZONE_BOUNDARY = 2'b01,
    ZONE_ACTIVE = 2'b10
  } ispr_zone_e;

  typedef struct packed {
    logic [1:0] rowSkip;
    logic [1:0] rowBin;
    ispr_mode_e mode;
    logic fixedBlackLevel;
    logic showDarkRows;
  } ispr_ctrl_s;

endpackage : ispr_pkg

// >>> design/ispr_readout.sv
// Purpose: Pixel readout and output pins of a 12-bit image sensor
// Assumes: masterInputClock is slow against sys_clk and is sampled; Wishbone classic slave
// Notes: Notes on behaviour below
`timescale 1ns/1ps
`include "ispr_params.svh"

module ispr_readout #(
  parameter int IMG_W = 2592,
  parameter int IMG_H = 1944,
  parameter int VBLANK_ROWS = 26,
  parameter int ROW_TAIL = 1,
  parameter logic [7:0] ADDR_HIGH = 8'h5A, // Arbitrary value
  parameter logic [7:0] ADDR_LOW = 8'h3C // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic chipResetN,
  input wire logic masterInputClock,
  input wire logic outFloat,
  input wire logic standbyN,
  input wire logic trigger,
  input wire logic busAddressSelect,
  output logic pixClkOut,
  output logic [11:0] pixData,
  output logic frameWindowShort,
  output logic lineWindowShort,
  output logic flashStrobe,
  output logic pinOe,
  output logic [7:0] devAddr,
  output logic standbyActive
);

  localparam logic [15:0] W16 = 16'(IMG_W);
  localparam logic [15:0] H16 = 16'(IMG_H);
  localparam logic [15:0] VB16 = 16'(VBLANK_ROWS);
  localparam logic [15:0] ROW_LEN = 16'(`ISPR_LV_OFFSET + IMG_W + ROW_TAIL);
  localparam logic [15:0] DARK_END = 16'(VBLANK_ROWS) + `ISPR_DARK_ROWS;
  localparam logic [15:0] FRAME_ROWS = 16'(VBLANK_ROWS + IMG_H) + `ISPR_DARK_ROWS;

  function automatic ispr_pkg::ispr_zone_e zoneOf(input logic [15:0] a, input logic [15:0] e0,
      input logic [15:0] e1, input logic [15:0] e2, input logic [15:0] e3);
    if (a <= e0 || a > e3) begin
      zoneOf = ispr_pkg::ZONE_DARK;
    end else if (a <= e1 || a > e2) begin
      zoneOf = ispr_pkg::ZONE_BOUNDARY;
    end else begin
      zoneOf = ispr_pkg::ZONE_ACTIVE;
    end
  endfunction : zoneOf

  // Pin synchronisers: stage one feeds stage two only
  logic [5:0] pinS1_q;
  logic [5:0] pinS2_q;
  logic mclkLast_q;
  logic trigLast_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // Idle levels: trigger and pixel clock low, so no false edge follows reset
      pinS1_q <= 6'h2D;
      pinS2_q <= 6'h2D;
    end else begin
      pinS1_q <= {busAddressSelect, trigger, standbyN, outFloat, masterInputClock, chipResetN};
      pinS2_q <= pinS1_q;
    end
  end

  logic resetNS;
  logic mclkS;
  logic floatS;
  logic standbyNS;
  logic trigS;
  logic addrSelS;
  assign resetNS = pinS2_q[0];
  assign mclkS = pinS2_q[1];
  assign floatS = pinS2_q[2];
  assign standbyNS = pinS2_q[3];
  assign trigS = pinS2_q[4];
  assign addrSelS = pinS2_q[5];

  logic chipRst;
  assign chipRst = srst | ~resetNS;

  logic tick;
  logic trigRise;
  assign tick = mclkS & ~mclkLast_q;
  assign trigRise = trigS & ~trigLast_q;

  // Trigger history moves per pixel clock, so a rise is still seen at the next tick
  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      mclkLast_q <= mclkS;
      trigLast_q <= trigS;
    end else begin
      mclkLast_q <= mclkS;
      if (tick) begin
        trigLast_q <= trigS;
      end
    end
  end

  // Register file
  ispr_pkg::ispr_ctrl_s ctrl_q;
  logic [15:0] expoRows_q;
  logic [15:0] frameCount_q;
  logic [31:0] rdData_d;
  logic wbReq;
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      ctrl_q <= ispr_pkg::ispr_ctrl_s'(`ISPR_CTRL_RST);
      expoRows_q <= `ISPR_EXPO_RST;
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i == `ISPR_REG_CTRL && wb_sel_i[0]) begin
        ctrl_q <= ispr_pkg::ispr_ctrl_s'(wb_dat_i[7:0]);
      end
      if (wb_adr_i == `ISPR_REG_EXPO) begin
        if (wb_sel_i[0]) begin
          expoRows_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          expoRows_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // State and counters
  ispr_pkg::ispr_state_e state_q;
  logic [15:0] hCnt_q;
  logic [15:0] rowCnt_q;
  logic rowEnd;
  logic frameEnd;
  logic darkRead;
  assign rowEnd = hCnt_q == ROW_LEN - 16'h0001;
  assign frameEnd = rowEnd && rowCnt_q == FRAME_ROWS - 16'h0001;
  assign darkRead = ctrl_q.showDarkRows | ~ctrl_q.fixedBlackLevel;

  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      state_q <= ispr_pkg::ST_WAIT;
      hCnt_q <= 16'h0000;
      rowCnt_q <= 16'h0000;
    end else if (standbyNS && tick) begin
      hCnt_q <= rowEnd || state_q == ispr_pkg::ST_WAIT ? 16'h0000 : hCnt_q + 16'h0001;
      case (state_q)
        ispr_pkg::ST_WAIT: begin
          rowCnt_q <= 16'h0000;
          if (ctrl_q.mode == ispr_pkg::MODE_CONT) begin
            state_q <= ispr_pkg::ST_READOUT;
          end else if (trigRise) begin
            state_q <= ispr_pkg::ST_EXPOSE;
          end
        end
        ispr_pkg::ST_EXPOSE: begin
          if (ctrl_q.mode == ispr_pkg::MODE_BULB) begin
            if (!trigS) begin
              state_q <= ispr_pkg::ST_READOUT;
              hCnt_q <= 16'h0000;
              rowCnt_q <= 16'h0000;
            end
          end else if (rowEnd) begin
            if (rowCnt_q + 16'h0001 >= expoRows_q) begin
              state_q <= ispr_pkg::ST_READOUT;
              rowCnt_q <= 16'h0000;
            end else begin
              rowCnt_q <= rowCnt_q + 16'h0001;
            end
          end
        end
        ispr_pkg::ST_READOUT: begin
          if (frameEnd) begin
            rowCnt_q <= 16'h0000;
            if (ctrl_q.mode != ispr_pkg::MODE_CONT) begin
              state_q <= ispr_pkg::ST_WAIT;
            end
          end else if (rowEnd) begin
            rowCnt_q <= rowCnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ispr_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // Row and column addressing
  logic darkRow;
  logic activeRow;
  logic inLine;
  logic [15:0] darkIdx;
  logic [15:0] actIdx;
  logic [15:0] arrayRow;
  logic [15:0] arrayCol;
  logic fvNext;
  logic lvNext;
  ispr_pkg::ispr_chan_e chan;
  assign darkRow = rowCnt_q >= VB16 && rowCnt_q < DARK_END && darkRead;
  assign activeRow = rowCnt_q >= DARK_END && rowCnt_q < FRAME_ROWS;
  assign inLine = hCnt_q >= `ISPR_LV_OFFSET && hCnt_q < `ISPR_LV_OFFSET + W16;
  assign darkIdx = rowCnt_q - VB16;
  assign actIdx = rowCnt_q - DARK_END;
  // Dark rows: bin spacing, skip ignored
  assign arrayRow = darkRow ? 16'(darkIdx * ({14'h0000, ctrl_q.rowBin} + 16'h0001))
                            : 16'(`ISPR_FIRST_ROW + actIdx * ({14'h0000, ctrl_q.rowSkip} + 16'h0001));
  assign arrayCol = `ISPR_FIRST_COL + (hCnt_q - `ISPR_LV_OFFSET);
  assign chan = ispr_pkg::ispr_chan_e'({arrayRow[0], arrayCol[0]});
  assign fvNext = state_q == ispr_pkg::ST_READOUT && (activeRow || (darkRow && ctrl_q.showDarkRows));
  assign lvNext = fvNext && inLine;

  // Output stage: windows, data and position once per pixel clock, the rest every sys_clk
  logic pixClk_q;
  logic [11:0] pixData_q;
  logic fv_q;
  logic lv_q;
  logic strobe_q;
  logic oe_q;
  logic [7:0] devAddr_q;
  logic standby_q;
  logic [15:0] posRow_q;
  logic [15:0] posCol_q;

  always_ff @(posedge sys_clk) begin
    if (chipRst || !standbyNS) begin
      pixClk_q <= 1'b0;
      pixData_q <= 12'h000;
      fv_q <= 1'b0;
      lv_q <= 1'b0;
      posRow_q <= 16'h0000;
      posCol_q <= 16'h0000;
    end else begin
      pixClk_q <= mclkS;
      if (tick) begin
        fv_q <= fvNext;
        lv_q <= lvNext;
        pixData_q <= lvNext ? {chan, arrayCol[9:0]} : 12'h000;
        if (lvNext) begin
          posRow_q <= arrayRow;
          posCol_q <= arrayCol;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= state_q == ispr_pkg::ST_EXPOSE && standbyNS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      oe_q <= 1'b0;
      devAddr_q <= 8'h00;
      standby_q <= 1'b0;
    end else begin
      oe_q <= ~floatS;
      devAddr_q <= addrSelS ? ADDR_HIGH : ADDR_LOW;
      standby_q <= ~standbyNS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (chipRst) begin
      frameCount_q <= 16'h0000;
    end else if (standbyNS && tick && state_q == ispr_pkg::ST_READOUT && frameEnd) begin
      frameCount_q <= frameCount_q + 16'h0001;
    end
  end

  // Current pixel zones, readable by software
  ispr_pkg::ispr_zone_e colZone;
  ispr_pkg::ispr_zone_e rowZone;
  assign colZone = zoneOf(posCol_q, `ISPR_COL_DARK0_END, `ISPR_COL_BND0_END,
                          `ISPR_COL_ACT_END, `ISPR_COL_BND1_END);
  assign rowZone = zoneOf(posRow_q, `ISPR_ROW_DARK0_END, `ISPR_ROW_BND0_END,
                          `ISPR_ROW_ACT_END, `ISPR_ROW_BND1_END);

  always_comb begin
    case (wb_adr_i)
      `ISPR_REG_CTRL: rdData_d = {24'h00_0000, ctrl_q};
      `ISPR_REG_EXPO: rdData_d = {16'h0000, expoRows_q};
      `ISPR_REG_STATUS: rdData_d = {frameCount_q, devAddr_q, 2'b00, state_q,
                                    strobe_q, standby_q, lv_q, fv_q};
      `ISPR_REG_POS: rdData_d = {rowZone, posRow_q[13:0], colZone, posCol_q[13:0]};
      default: rdData_d = 32'h0000_0000;
    endcase
  end

  logic ack_q;
  logic [31:0] dat_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wbReq;
      dat_q <= wbReq && !wb_we_i ? rdData_d : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pixClkOut = pixClk_q;
  assign pixData = pixData_q;
  assign frameWindowShort = fv_q;
  assign lineWindowShort = lv_q;
  assign flashStrobe = strobe_q;
  assign pinOe = oe_q;
  assign devAddr = devAddr_q;
  assign standbyActive = standby_q;

endmodule : ispr_readout

// >>> sim/ispr_rx_model.sv
// Purpose: Image receiver model on the pixel bus
// Assumes: Drives nothing back
// Notes: Keeps first word and length of the last line
`timescale 1ns/1ps
module ispr_rx_model (
  input wire logic pixClkOut,
  input wire logic [11:0] pixData,
  input wire logic frameWindowShort,
  input wire logic lineWindowShort,
  output logic [15:0] lineLen,
  output logic [11:0] firstWord
);
  logic [15:0] runQ;
  logic lvQ;
  initial begin
    runQ = 16'h0000;
    lvQ = 1'b0;
    lineLen = 16'h0000;
    firstWord = 12'h000;
  end
  always @(negedge pixClkOut) begin
    lvQ <= lineWindowShort;
    if (frameWindowShort && lineWindowShort) begin
      if (runQ == 16'h0000) firstWord <= pixData;
      runQ <= runQ + 16'h0001;
    end else if (lvQ) begin
      lineLen <= runQ;
      runQ <= 16'h0000;
    end
  end
endmodule : ispr_rx_model

// >>> sim/ispr_assertions.sv
// Purpose: Port checks of the pixel readout
// Assumes: Pixel clock edges found on sys_clk
// Notes: Bound to ispr_readout
`timescale 1ns/1ps
module ispr_assertions #(
  parameter int IMG_W = 2592,
  parameter logic [7:0] ADDR_HIGH = 8'h5A,
  parameter logic [7:0] ADDR_LOW = 8'h3C
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_ack_o,
  input wire logic chipResetN,
  input wire logic outFloat,
  input wire logic standbyN,
  input wire logic busAddressSelect,
  input wire logic pixClkOut,
  input wire logic [11:0] pixData,
  input wire logic frameWindowShort,
  input wire logic lineWindowShort,
  input wire logic pinOe,
  input wire logic [7:0] devAddr,
  input wire logic standbyActive
);
  logic pcQ;
  logic firstQ;
  logic [15:0] fvCnt;
  logic [15:0] lvCnt;
  wire pcRise = pixClkOut && !pcQ;
  always_ff @(posedge sys_clk) begin
    pcQ <= pixClkOut;
  end
  always_ff @(posedge sys_clk) begin
    if (!frameWindowShort) fvCnt <= 16'h0000;
    else if (pcRise) fvCnt <= fvCnt + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (!lineWindowShort) lvCnt <= 16'h0000;
    else if (pcRise) lvCnt <= lvCnt + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (!frameWindowShort) firstQ <= 1'b1;
    else if (lineWindowShort) firstQ <= 1'b0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  float_off_a: assert property (outFloat [*4] |=> !pinOe)
    else $error("pins driven while floated");
  drive_on_a: assert property ((!outFloat && chipResetN) [*6] |=> pinOe)
    else $error("pins not driven");
  standby_in_a: assert property ((!standbyN && chipResetN) [*6] |=> standbyActive)
    else $error("standby not entered");
  standby_out_a: assert property ((standbyN && chipResetN) [*6] |=> !standbyActive)
    else $error("standby not left");
  standby_dark_a: assert property (standbyActive && $past(standbyActive) |-> !frameWindowShort)
    else $error("frame window in standby");
  addr_high_a: assert property ((busAddressSelect && chipResetN) [*6] |=> devAddr == ADDR_HIGH)
    else $error("wrong high address");
  addr_low_a: assert property ((!busAddressSelect && chipResetN) [*6] |=> devAddr == ADDR_LOW)
    else $error("wrong low address");
  lv_in_fv_a: assert property (lineWindowShort |-> frameWindowShort)
    else $error("line window outside frame");
  pix_blank_a: assert property (!lineWindowShort |-> pixData == 12'h000)
    else $error("data outside line window");
  lv_delay_a: assert property ($rose(lineWindowShort) && firstQ |-> fvCnt == 16'h0261)
    else $error("line window offset wrong");
  line_len_a: assert property ($fell(lineWindowShort) |-> lvCnt == IMG_W)
    else $error("line length wrong");
  fv_rise_c: cover property ($rose(frameWindowShort));
  lv_rise_c: cover property ($rose(lineWindowShort));
  standby_c: cover property (standbyActive);
endmodule : ispr_assertions
bind ispr_readout ispr_assertions #(.IMG_W(IMG_W), .ADDR_HIGH(ADDR_HIGH), .ADDR_LOW(ADDR_LOW)) i_chk (
  .sys_clk, .srst, .wb_ack_o, .chipResetN, .outFloat, .standbyN, .busAddressSelect, .pixClkOut,
  .pixData, .frameWindowShort, .lineWindowShort, .pinOe, .devAddr, .standbyActive);

// >>> sim/testbench.sv
// Purpose: Self-checking bench of the pixel readout
// Assumes: Small image parameters
// Notes: Bus, pins and first frame
`timescale 1ns/1ps
module testbench;
  localparam int IMG_W = 16;
  logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, chipResetN, masterInputClock;
  logic outFloat, standbyN, trigger, busAddressSelect, pixClkOut, frameWindowShort;
  logic lineWindowShort, flashStrobe, pinOe, standbyActive;
  logic [7:0] wb_adr_i, devAddr;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [11:0] pixData, firstWord;
  logic [15:0] lineLen;
  int failures, checks_done;
  ispr_readout #(.IMG_W(IMG_W), .IMG_H(2), .VBLANK_ROWS(1)) i_dut (.sys_clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .chipResetN,
    .masterInputClock, .outFloat, .standbyN, .trigger, .busAddressSelect, .pixClkOut, .pixData,
    .frameWindowShort, .lineWindowShort, .flashStrobe, .pinOe, .devAddr, .standbyActive);
  ispr_rx_model i_rx (.pixClkOut, .pixData, .frameWindowShort, .lineWindowShort, .lineLen, .firstWord);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    masterInputClock = 1'b0;
    #7;
    forever #80 masterInputClock = ~masterInputClock;
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic sig(input int s);
    logic [2:0] v;
    v = {pixClkOut, lineWindowShort, frameWindowShort};
    return v[s];
  endfunction : sig
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge sys_clk);
      if (sig(s) === v) break;
    end
    if (n == lim) begin
      check("wait timeout", 32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
  endtask : wait_sig
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 50) begin
      check("ack timeout", 32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
  endtask : wb
  task automatic pin(input int s, input logic v);
    @(posedge sys_clk);
    case (s)
      0: outFloat <= v;
      1: standbyN <= v;
      2: busAddressSelect <= v;
      4: trigger <= v;
      default: chipResetN <= v;
    endcase
    repeat (8) @(negedge sys_clk);
  endtask : pin
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    wb(1'b1, 8'h04, 32'h0000_0020);
    wb(1'b0, 8'h04, 32'h0000_0000);
    check("expo write", rd, 32'h0000_0020);
    pin(3, 1'b0);
    check("oe in chip reset", pinOe, 32'h0000_0000);
    pin(3, 1'b1);
    wb(1'b0, 8'h04, 32'h0000_0000);
    check("expo default", rd, 32'h0000_0010);
    $display("done regs");
  endtask : t_regs
  task automatic t_pins;
    pin(2, 1'b0);
    check("addr low", devAddr, 32'h0000_003C);
    pin(2, 1'b1);
    check("addr high", devAddr, 32'h0000_005A);
    pin(0, 1'b1);
    check("oe floated", pinOe, 32'h0000_0000);
    pin(0, 1'b0);
    check("oe driven", pinOe, 32'h0000_0001);
    pin(1, 1'b0);
    check("standby in", standbyActive, 32'h0000_0001);
    pin(1, 1'b1);
    check("standby out", standbyActive, 32'h0000_0000);
    $display("done pins");
  endtask : t_pins
  task automatic t_frame;
    int n;
    int i;
    logic p;
    wait_sig(0, 1'b1, 60000);
    p = pixClkOut;
    n = 0;
    for (i = 0; i < 6000 && lineWindowShort !== 1'b1; i++) begin
      @(negedge sys_clk);
      if (pixClkOut && !p) n++;
      p = pixClkOut;
    end
    check("fv to lv clocks", n, 609);
    check("first pixel", pixData, 32'h0000_0010);
    wait_sig(2, 1'b0, 20);
    wait_sig(2, 1'b1, 20);
    check("second pixel", pixData, 32'h0000_0411);
    wait_sig(1, 1'b0, 1000);
    repeat (8) @(negedge sys_clk);
    check("line length", lineLen, IMG_W);
    check("captured first", firstWord, 32'h0000_0010);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    check("window zones", rd, 32'h8036_801F);
    wb(1'b1, 8'h00, 32'h0000_0008);
    check("fv in hblank", frameWindowShort, 32'h0000_0001);
    wait_sig(1, 1'b1, 6000);
    check("row two pixel", pixData, 32'h0000_0810);
    wait_sig(0, 1'b0, 6000);
    check("lv in vblank", lineWindowShort, 32'h0000_0000);
    $display("done frame");
  endtask : t_frame
  task automatic t_bulb;
    repeat (16) @(negedge sys_clk);
    check("strobe idle", flashStrobe, 32'h0000_0000);
    pin(4, 1'b1);
    repeat (16) @(negedge sys_clk);
    check("strobe in bulb", flashStrobe, 32'h0000_0001);
    check("fv in exposure", frameWindowShort, 32'h0000_0000);
    pin(4, 1'b0);
    repeat (16) @(negedge sys_clk);
    check("strobe after bulb", flashStrobe, 32'h0000_0000);
    $display("done bulb");
  endtask : t_bulb
  initial begin
    failures = 0;
    checks_done = 0;
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    chipResetN = 1'b1;
    outFloat = 1'b0;
    standbyN = 1'b1;
    trigger = 1'b0;
    busAddressSelect = 1'b1;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_pins();
    t_frame();
    t_bulb();
    report_and_stop();
  end
endmodule : testbench
